// file: shared/rbfc_pkg.sv
package rbfc_pkg;

	// register indices; byte address is four times the index
	localparam logic [7:0] RBFC_IDX_SPEED  = 8'h04;
	localparam logic [7:0] RBFC_IDX_AFRAME = 8'h05;
	localparam logic [7:0] RBFC_IDX_CMD    = 8'h08;
	localparam logic [7:0] RBFC_IDX_STATUS = 8'h09;
	localparam int         RBFC_ADDR_LSB   = 2;

	localparam logic [7:0] RBFC_SPEED_RST  = 8'h00;
	localparam logic [7:0] RBFC_AFRAME_RST = 8'h00;

	// speed register fields
	localparam int RBFC_SEND_MSB = 7;
	localparam int RBFC_SEND_LSB = 4;
	localparam int RBFC_RECV_MSB = 3;
	localparam int RBFC_RECV_LSB = 0;

	// type A framing fields
	localparam int RBFC_BIT_NO_TX_PARITY = 7;
	localparam int RBFC_BIT_RAW_RX       = 6;
	localparam int RBFC_BIT_TRANSPORT    = 5;
	localparam int RBFC_PAUSE_MSB        = 4;
	localparam int RBFC_PAUSE_LSB        = 1;
	localparam int RBFC_BIT_ANTICOLL     = 0;

	// command register bits (write one to execute)
	localparam int RBFC_CMD_LOAD_DEFAULTS = 0;
	localparam int RBFC_CMD_RESTORE_LINK  = 1;

	// speed codes, carrier divided by 2^(7-code)
	localparam logic [3:0] RBFC_RATE_DIV128 = 4'h0;
	localparam logic [3:0] RBFC_RATE_DIV64  = 4'h1;
	localparam logic [3:0] RBFC_RATE_DIV32  = 4'h2;
	localparam logic [3:0] RBFC_RATE_DIV16  = 4'h3;
	localparam logic [3:0] RBFC_RATE_DIV8   = 4'h4;
	localparam logic [3:0] RBFC_RATE_DIV4   = 4'h5;
	localparam logic [3:0] RBFC_RATE_DIV2   = 4'h6;

	// operating mode codes (initiator unless noted)
	localparam logic [3:0] RBFC_OM_ACTIVE_P2P = 4'h0;
	localparam logic [3:0] RBFC_OM_TYPE_A     = 4'h1;
	localparam logic [3:0] RBFC_OM_TYPE_B     = 4'h2;
	localparam logic [3:0] RBFC_OM_TYPE_F     = 4'h3;
	localparam logic [3:0] RBFC_OM_TYPE_1TAG  = 4'h4;
	localparam logic [3:0] RBFC_OM_SUBC_STRM  = 4'he;
	localparam logic [3:0] RBFC_OM_BPSK_STRM  = 4'hf;
	localparam logic [3:0] RBFC_OM_TGT_DETECT = 4'h0;
	localparam logic [3:0] RBFC_OM_TGT_NORMAL = 4'h1;

	// pause width: base at code 0 and signed code span per rate
	localparam logic [5:0] RBFC_PW_BASE128 = 6'd35;
	localparam logic [5:0] RBFC_PW_BASE64  = 6'd18;
	localparam logic [5:0] RBFC_PW_BASE32  = 6'd9;
	localparam logic [5:0] RBFC_PW_BASE16  = 6'd5;
	localparam logic signed [4:0] RBFC_PW_LO128 = -5'sd8;
	localparam logic signed [4:0] RBFC_PW_HI128 = 5'sd7;
	localparam logic signed [4:0] RBFC_PW_LO64  = -5'sd6;
	localparam logic signed [4:0] RBFC_PW_HI64  = 5'sd6;
	localparam logic signed [4:0] RBFC_PW_LO32  = -5'sd4;
	localparam logic signed [4:0] RBFC_PW_HI32  = 5'sd4;
	localparam logic signed [4:0] RBFC_PW_LO16  = -5'sd3;
	localparam logic signed [4:0] RBFC_PW_HI16  = 5'sd3;

	localparam logic [7:0] RBFC_TRANSPORT_START = 8'hf0;

	typedef struct packed {
		logic       tx_enable;
		logic       rx_enable;
		logic [3:0] send_rate;
		logic [3:0] recv_rate;
		logic       no_tx_parity;
		logic       raw_rx;
		logic       transport_frame_header;
		logic       anticoll_frame;
		logic       pause_valid;
		logic [5:0] pause_width;
	} rbfc_link_cfg_t;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] index;
		logic [7:0] wdata;
	} rbfc_reg_req_t;

	function automatic logic rbfc_rate_known(input logic [3:0] code);
		rbfc_rate_known = (code <= RBFC_RATE_DIV2);
	endfunction

endpackage

// file: design/rbfc_apb_port.sv
`timescale 1ns/1ps
module rbfc_apb_port
	import rbfc_pkg::*;
(
	input  wire logic        psel,    // slave select
	input  wire logic        penable, // access phase
	input  wire logic        pwrite,  // write direction
	input  wire logic [31:0] paddr,   // byte address
	input  wire logic [31:0] pwdata,  // write data
	input  wire logic        mapped,  // index decodes to a register
	output rbfc_pkg::rbfc_reg_req_t req, // register request
	output logic             pready,  // always ready
	output logic             pslverr  // unmapped access
);
	logic access;
	logic aligned_hi;

	// zero wait states: every access completes in its first access cycle
	assign access     = psel & penable;
	assign aligned_hi = (paddr[31:RBFC_ADDR_LSB + 8] == '0);
	assign pready     = 1'b1;
	assign pslverr    = access & ~(mapped & aligned_hi);

	always_comb
	begin
		req.index = paddr[RBFC_ADDR_LSB + 7:RBFC_ADDR_LSB];
		req.wdata = pwdata[7:0];
		req.wr    = access & pwrite & mapped & aligned_hi;
		req.rd    = access & ~pwrite;
	end
endmodule

// file: design/rbfc_pause_decode.sv
`timescale 1ns/1ps
module rbfc_pause_decode
	import rbfc_pkg::*;
(
	input  wire logic [3:0] code,  // pause width code
	input  wire logic [3:0] rate,  // send speed code
	output logic            valid, // code usable at this rate
	output logic [5:0]      width  // pause in carrier periods
);
	logic signed [4:0] offs;
	logic signed [4:0] lo;
	logic signed [4:0] hi;
	logic        [5:0] base;

	// code is a two's complement offset from the rate's base width
	assign offs = {code[3], code};

	always_comb
	begin
		base = RBFC_PW_BASE128;
		lo   = RBFC_PW_LO128;
		hi   = RBFC_PW_HI128;
		case (rate)
			RBFC_RATE_DIV128:
			begin
				base = RBFC_PW_BASE128;
				lo   = RBFC_PW_LO128;
				hi   = RBFC_PW_HI128;
			end
			RBFC_RATE_DIV64:
			begin
				base = RBFC_PW_BASE64;
				lo   = RBFC_PW_LO64;
				hi   = RBFC_PW_HI64;
			end
			RBFC_RATE_DIV32:
			begin
				base = RBFC_PW_BASE32;
				lo   = RBFC_PW_LO32;
				hi   = RBFC_PW_HI32;
			end
			RBFC_RATE_DIV16:
			begin
				base = RBFC_PW_BASE16;
				lo   = RBFC_PW_LO16;
				hi   = RBFC_PW_HI16;
			end
			default:
			begin
				base = RBFC_PW_BASE128;
				lo   = RBFC_PW_HI128;
				hi   = RBFC_PW_LO128;
			end
		endcase
	end

	assign valid = (offs >= lo) && (offs <= hi);
	assign width = valid ? 6'(base + 6'({{1{offs[4]}}, offs})) : 6'h00;
endmodule

// file: design/rbfc_top.sv
// Our own choice: register access over APB.
`timescale 1ns/1ps
// Overview of operation
// - upper nibble selects send bit rate
// - lower nibble sets receive rate when allowed
// - both registers clear at reset, defaults
// - restore link command reloads speed register
// - codes 0..6 map carrier/128 to carrier/2
// - send above carrier/16 only in type B
// - very high receive only carrier/8, /4
// - unsupported speed code disables send, receive
// - bit 7 sends without parity bits
// - bit 6 receives raw, no checks
// - bit 5 adds/strips F0 header, length
// - bits 4..1 set pause at carrier/128
// - faster rates shift base, invalid codes
// - unsupported operating mode disables send, receive
module rbfc_top
	import rbfc_pkg::*;
(
	input  wire logic        CLK,            // 40 MHz clock
	input  wire logic        SRST,           // sync reset, high
	input  wire logic        PSEL,           // apb select
	input  wire logic        PENABLE,        // apb enable
	input  wire logic        PWRITE,         // apb write
	input  wire logic [31:0] PADDR,          // apb address
	input  wire logic [31:0] PWDATA,         // apb write data
	output logic      [31:0] PRDATA,         // apb read data
	output logic             PREADY,         // apb ready
	output logic             PSLVERR,        // apb error
	input  wire logic        TARGET_MODE,    // device acts as target
	input  wire logic [3:0]  OP_MODE,        // operating mode code
	input  wire logic [3:0]  DETECTED_RATE,  // rate for link restore
	input  wire logic        TX_FRAME_START, // send frame begins
	input  wire logic        RX_FRAME_START, // receive frame begins
	input  wire logic        FRAME_DONE,     // current frame ended
	output rbfc_pkg::rbfc_link_cfg_t LINK_CFG, // settings in force
	output logic [7:0]       START_BYTE,     // transport start byte
	output logic             LINK_BUSY       // frame in progress
);
	typedef enum logic [2:0]
	{
		RBFC_LINK_IDLE = 3'b001,
		RBFC_LINK_SEND = 3'b010,
		RBFC_LINK_RECV = 3'b100
	} rbfc_link_state_t;

	rbfc_reg_req_t    req;
	rbfc_link_state_t state;
	rbfc_link_state_t next_state;
	rbfc_link_cfg_t   next_cfg;
	rbfc_link_cfg_t   cfg;

	logic [7:0] link_speed_select;
	logic [7:0] type_a_framing_settings;
	logic       mapped;
	logic       cmd_load_defaults;
	logic       cmd_restore_link;
	logic       mode_ok;
	logic       split_rates;
	logic       send_ok;
	logic       recv_ok;
	logic [3:0] send_speed_code;
	logic [3:0] receive_speed_code;
	logic [3:0] recv_used;
	logic [3:0] pause_width_code;
	logic       pause_valid;
	logic [5:0] pause_width;
	logic       pending;
	logic [7:0] status;
	logic       frame_start;

	function automatic logic rbfc_is_very_high(input logic [3:0] code);
		rbfc_is_very_high = (code >= RBFC_RATE_DIV8)
			&& rbfc_rate_known(code);
	endfunction

	rbfc_apb_port u_apb
	(
		.psel    (PSEL),
		.penable (PENABLE),
		.pwrite  (PWRITE),
		.paddr   (PADDR),
		.pwdata  (PWDATA),
		.mapped  (mapped),
		.req     (req),
		.pready  (PREADY),
		.pslverr (PSLVERR)
	);

	always_comb
	begin
		case (req.index)
			RBFC_IDX_SPEED:  mapped = 1'b1;
			RBFC_IDX_AFRAME: mapped = 1'b1;
			RBFC_IDX_CMD:    mapped = 1'b1;
			RBFC_IDX_STATUS: mapped = 1'b1;
			default:         mapped = 1'b0;
		endcase
	end

	// command bits are self clearing strobes, never stored
	assign cmd_load_defaults = req.wr && (req.index == RBFC_IDX_CMD)
		&& req.wdata[RBFC_CMD_LOAD_DEFAULTS];
	assign cmd_restore_link  = req.wr && (req.index == RBFC_IDX_CMD)
		&& req.wdata[RBFC_CMD_RESTORE_LINK];

	// speed register; defaults outrank restore, restore outranks a write
	always_ff @(posedge CLK)
	begin
		if (SRST || cmd_load_defaults)
			link_speed_select <= RBFC_SPEED_RST;
		else if (cmd_restore_link)
			link_speed_select <= {DETECTED_RATE, DETECTED_RATE};
		else if (req.wr && (req.index == RBFC_IDX_SPEED))
			link_speed_select <= req.wdata;
	end

	// framing register
	always_ff @(posedge CLK)
	begin
		if (SRST || cmd_load_defaults)
			type_a_framing_settings <= RBFC_AFRAME_RST;
		else if (req.wr && (req.index == RBFC_IDX_AFRAME))
			type_a_framing_settings <= req.wdata;
	end

	assign send_speed_code    = link_speed_select[RBFC_SEND_MSB:RBFC_SEND_LSB];
	assign receive_speed_code = link_speed_select[RBFC_RECV_MSB:RBFC_RECV_LSB];
	assign pause_width_code   =
		type_a_framing_settings[RBFC_PAUSE_MSB:RBFC_PAUSE_LSB];

	// operating modes that exist; anything else halts the link
	always_comb
	begin
		if (TARGET_MODE)
		begin
			case (OP_MODE)
				RBFC_OM_TGT_DETECT: mode_ok = 1'b1;
				RBFC_OM_TGT_NORMAL: mode_ok = 1'b1;
				default:            mode_ok = 1'b0;
			endcase
		end
		else
		begin
			case (OP_MODE)
				RBFC_OM_ACTIVE_P2P: mode_ok = 1'b1;
				RBFC_OM_TYPE_A:     mode_ok = 1'b1;
				RBFC_OM_TYPE_B:     mode_ok = 1'b1;
				RBFC_OM_TYPE_F:     mode_ok = 1'b1;
				RBFC_OM_TYPE_1TAG:  mode_ok = 1'b1;
				RBFC_OM_SUBC_STRM:  mode_ok = 1'b1;
				RBFC_OM_BPSK_STRM:  mode_ok = 1'b1;
				default:            mode_ok = 1'b0;
			endcase
		end
	end

	// only type A and type B readers may run asymmetric rates
	assign split_rates = ~TARGET_MODE
		&& ((OP_MODE == RBFC_OM_TYPE_A) || (OP_MODE == RBFC_OM_TYPE_B));
	assign recv_used   = split_rates ? receive_speed_code
		: send_speed_code;

	// send rate must exist, and very high rates need type B
	assign send_ok = rbfc_rate_known(send_speed_code)
		&& (~rbfc_is_very_high(send_speed_code)
		|| (~TARGET_MODE && (OP_MODE == RBFC_OM_TYPE_B)));

	// carrier/2 exists for sending but never for reception
	assign recv_ok = rbfc_rate_known(recv_used)
		&& (recv_used != RBFC_RATE_DIV2);

	rbfc_pause_decode u_pause
	(
		.code  (pause_width_code),
		.rate  (send_speed_code),
		.valid (pause_valid),
		.width (pause_width)
	);

	// settings the next frame would run with
	always_comb
	begin
		next_cfg.tx_enable    = mode_ok && send_ok && recv_ok;
		next_cfg.rx_enable    = mode_ok && send_ok && recv_ok;
		next_cfg.send_rate    = send_speed_code;
		next_cfg.recv_rate    = recv_used;
		next_cfg.no_tx_parity =
			type_a_framing_settings[RBFC_BIT_NO_TX_PARITY];
		next_cfg.raw_rx       =
			type_a_framing_settings[RBFC_BIT_RAW_RX];
		next_cfg.transport_frame_header =
			type_a_framing_settings[RBFC_BIT_TRANSPORT];
		next_cfg.anticoll_frame =
			type_a_framing_settings[RBFC_BIT_ANTICOLL];
		next_cfg.pause_valid  = pause_valid;
		next_cfg.pause_width  = pause_width;
	end

	assign frame_start = TX_FRAME_START | RX_FRAME_START;

	// frame tracker; a start while busy is ignored
	always_comb
	begin
		next_state = state;
		case (state)
			RBFC_LINK_IDLE:
			begin
				if (TX_FRAME_START && cfg.tx_enable)
					next_state = RBFC_LINK_SEND;
				else if (RX_FRAME_START && cfg.rx_enable)
					next_state = RBFC_LINK_RECV;
			end
			RBFC_LINK_SEND:
			begin
				if (FRAME_DONE)
					next_state = RBFC_LINK_IDLE;
			end
			RBFC_LINK_RECV:
			begin
				if (FRAME_DONE)
					next_state = RBFC_LINK_IDLE;
			end
			default:
				next_state = RBFC_LINK_IDLE;
		endcase
	end

	always_ff @(posedge CLK)
	begin
		if (SRST)
			state <= RBFC_LINK_IDLE;
		else
			state <= next_state;
	end

	// settings in force only change between frames, so a frame
	// never sees a rate or header switch halfway through
	always_ff @(posedge CLK)
	begin
		if (SRST)
			cfg <= '0;
		else if (state == RBFC_LINK_IDLE && !frame_start)
			cfg <= next_cfg;
	end

	// shows that a write is still waiting for the frame to end
	assign pending = (cfg != next_cfg);

	always_comb
	begin
		status    = 8'h00;
		status[0] = cfg.tx_enable;
		status[1] = cfg.rx_enable;
		status[2] = mode_ok;
		status[3] = send_ok;
		status[4] = recv_ok;
		status[5] = pause_valid;
		status[6] = pending;
		status[7] = (state != RBFC_LINK_IDLE);
	end

	// read data registered in the access cycle's own edge is too late
	// for zero-wait apb, so reads are combinational from flops
	always_comb
	begin
		PRDATA = 32'h0000_0000;
		if (req.rd)
		begin
			case (req.index)
				RBFC_IDX_SPEED:  PRDATA[7:0] = link_speed_select;
				RBFC_IDX_AFRAME: PRDATA[7:0] = type_a_framing_settings;
				RBFC_IDX_STATUS: PRDATA[7:0] = status;
				default:         PRDATA = 32'h0000_0000;
			endcase
		end
	end

	assign LINK_CFG   = cfg;
	assign LINK_BUSY  = (state != RBFC_LINK_IDLE);
	assign START_BYTE = RBFC_TRANSPORT_START;
endmodule

// file: verification/rbfc_top_properties.sv
`timescale 1ns/1ps
module rbfc_props
	import rbfc_pkg::*;
(
	input wire logic       CLK,            // clock
	input wire logic       SRST,           // reset
	input wire logic       PSLVERR,        // apb error
	input wire logic       TARGET_MODE,    // target mode
	input wire logic [3:0] OP_MODE,        // mode code
	input wire logic       TX_FRAME_START, // send start
	input wire logic       RX_FRAME_START, // receive start
	input wire logic       FRAME_DONE,     // frame end
	input rbfc_pkg::rbfc_link_cfg_t LINK_CFG, // settings
	input wire logic [7:0] START_BYTE,     // start byte
	input wire logic       LINK_BUSY       // frame running
);
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (SRST);
	logic idle;
	logic bad_mode;
	assign idle = !LINK_BUSY && !TX_FRAME_START && !RX_FRAME_START;
	assign bad_mode = TARGET_MODE ? OP_MODE > 4'h1
		: (OP_MODE > 4'h4 && OP_MODE < 4'he);

	a_busy_start: assert property (!LINK_BUSY && TX_FRAME_START
		&& LINK_CFG.tx_enable |=> LINK_BUSY) else $error("start lost");
	a_busy_hold: assert property (LINK_BUSY && !FRAME_DONE
		|=> LINK_BUSY) else $error("busy dropped");
	a_busy_end: assert property (LINK_BUSY && FRAME_DONE
		|=> !LINK_BUSY) else $error("busy stuck");
	a_cfg_frozen: assert property (LINK_BUSY
		|=> $stable(LINK_CFG)) else $error("cfg moved in frame");
	a_start_byte: assert property (
		START_BYTE == RBFC_TRANSPORT_START) else $error("start byte");
	a_mode_off: assert property (idle && bad_mode
		|=> !LINK_CFG.tx_enable && !LINK_CFG.rx_enable)
		else $error("bad mode enabled");
	a_rate_off: assert property (LINK_CFG.send_rate > RBFC_RATE_DIV2
		|-> !LINK_CFG.tx_enable && !LINK_CFG.rx_enable)
		else $error("bad rate enabled");
	a_fast_typeb: assert property (idle
		&& (TARGET_MODE || OP_MODE != RBFC_OM_TYPE_B)
		|=> !LINK_CFG.tx_enable || LINK_CFG.send_rate < RBFC_RATE_DIV8)
		else $error("fast send outside type B");
	a_fast_recv: assert property (LINK_CFG.rx_enable
		|-> LINK_CFG.recv_rate != RBFC_RATE_DIV2) else $error("rx fc/2");

	c_frame: cover property (LINK_BUSY && FRAME_DONE);
	c_refused: cover property (PSLVERR);
	c_fast: cover property (LINK_CFG.tx_enable && LINK_CFG.send_rate == 4'h5);
endmodule

bind rbfc_top rbfc_props i_rbfc_props (.CLK(CLK), .SRST(SRST),
	.PSLVERR(PSLVERR), .TARGET_MODE(TARGET_MODE), .OP_MODE(OP_MODE),
	.TX_FRAME_START(TX_FRAME_START), .RX_FRAME_START(RX_FRAME_START),
	.FRAME_DONE(FRAME_DONE), .LINK_CFG(LINK_CFG),
	.START_BYTE(START_BYTE), .LINK_BUSY(LINK_BUSY));

// file: verification/testbench.sv
`timescale 1ns/1ps
module testbench;
	import rbfc_pkg::*;
	logic        CLK, SRST, PSEL, PENABLE, PWRITE, TARGET_MODE;
	logic        TX_FRAME_START, RX_FRAME_START, FRAME_DONE;
	logic        PREADY, PSLVERR, LINK_BUSY, er;
	logic [31:0] PADDR, PWDATA, PRDATA;
	logic [3:0]  OP_MODE, DETECTED_RATE;
	logic [7:0]  START_BYTE, rd;
	rbfc_link_cfg_t LINK_CFG;
	int          mismatches = 0;
	int          n_tests = 0;
	int          cyc = 0;
	// pause width per speed code 0..3: base, lowest and highest offset
	int          pw_base[4] = '{35, 18, 9, 5};
	int          pw_lo[4]   = '{-8, -6, -4, -3};
	int          pw_hi[4]   = '{7, 6, 4, 3};

	rbfc_top i_rbfc_top (.CLK, .SRST, .PSEL, .PENABLE, .PWRITE, .PADDR,
		.PWDATA, .PRDATA, .PREADY, .PSLVERR, .TARGET_MODE, .OP_MODE,
		.DETECTED_RATE, .TX_FRAME_START, .RX_FRAME_START, .FRAME_DONE,
		.LINK_CFG, .START_BYTE, .LINK_BUSY);

	always #12.5 CLK = ~CLK;

	task chk(input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e)
		begin
			mismatches++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	task tally_and_finish;
		$display("comparisons=%0d mismatches=%0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// hang guard, whole run needs far fewer cycles
	always @(posedge CLK)
	begin
		cyc <= cyc + 1;
		if (cyc == 8000)
		begin
			mismatches++;
			tally_and_finish;
		end
	end

	task apb(input logic w, input logic [7:0] i, input logic [7:0] d);
		@(posedge CLK);
		PSEL <= 1'h1;
		PWRITE <= w;
		PADDR <= {22'h0, i, 2'h0};
		PWDATA <= {24'h0, d};
		@(posedge CLK);
		PENABLE <= 1'h1;
		do
			@(posedge CLK);
		while (PREADY !== 1'h1);
		rd = PRDATA[7:0];
		er = PSLVERR;
		PSEL <= 1'h0;
		PENABLE <= 1'h0;
	endtask

	// write, then let the settings reach the output
	task wr(input logic [7:0] i, input logic [7:0] d);
		apb(1'h1, i, d);
		repeat (2) @(posedge CLK);
	endtask

	task rdchk(input logic [7:0] i, input logic [7:0] e);
		apb(1'h0, i, 8'h0);
		chk(rd, e);
	endtask

	// one-cycle start pulse, then one edge so the state is visible
	task start_frame(input logic tx);
		TX_FRAME_START <= tx;
		RX_FRAME_START <= !tx;
		@(posedge CLK);
		TX_FRAME_START <= 1'h0;
		RX_FRAME_START <= 1'h0;
		@(posedge CLK);
	endtask

	// frame end, then the idle edge at which pending settings load
	task end_frame;
		FRAME_DONE <= 1'h1;
		@(posedge CLK);
		FRAME_DONE <= 1'h0;
		repeat (2) @(posedge CLK);
	endtask

	task md(input logic t, input logic [3:0] m);
		TARGET_MODE <= t;
		OP_MODE <= m;
		repeat (2) @(posedge CLK);
	endtask

	task t_reset;
		rdchk(RBFC_IDX_SPEED, 8'h00);
		rdchk(RBFC_IDX_AFRAME, 8'h00);
		chk(LINK_CFG.pause_width, 6'h23);
		chk({LINK_CFG.tx_enable, LINK_CFG.rx_enable}, 2'h3);
		chk(START_BYTE, 8'hf0);
		$display("reset done");
	endtask

	task t_rates;
		int c;
		md(1'h0, RBFC_OM_TYPE_B);
		for (c = 0; c < 16; c++)
		begin
			wr(RBFC_IDX_SPEED, {c[3:0], c[3:0]});
			rdchk(RBFC_IDX_SPEED, {c[3:0], c[3:0]});
			chk(LINK_CFG.send_rate, c[3:0]);
			chk(LINK_CFG.tx_enable, c < 6);
		end
		md(1'h0, RBFC_OM_TYPE_A);
		wr(RBFC_IDX_SPEED, 8'h13);
		chk(LINK_CFG.recv_rate, 4'h3);
		wr(RBFC_IDX_SPEED, 8'h41);
		chk(LINK_CFG.tx_enable, 1'h0);
		md(1'h0, RBFC_OM_TYPE_F);
		wr(RBFC_IDX_SPEED, 8'h13);
		chk(LINK_CFG.recv_rate, 4'h1);
		$display("rates done");
	endtask

	task t_mode;
		wr(RBFC_IDX_SPEED, 8'h00);
		md(1'h0, 4'h5);
		chk(LINK_CFG.rx_enable, 1'h0);
		md(1'h1, RBFC_OM_TGT_NORMAL);
		chk(LINK_CFG.rx_enable, 1'h1);
		md(1'h1, 4'h2);
		chk(LINK_CFG.tx_enable, 1'h0);
		$display("modes done");
	endtask

	task t_framing;
		int c;
		logic [1:0] r;
		logic [3:0] f;
		logic signed [4:0] s;
		logic v;
		md(1'h0, RBFC_OM_TYPE_A);
		wr(RBFC_IDX_AFRAME, 8'he1);
		f = {LINK_CFG.no_tx_parity, LINK_CFG.raw_rx,
			LINK_CFG.transport_frame_header, LINK_CFG.anticoll_frame};
		chk(f, 4'hf);
		wr(RBFC_IDX_AFRAME, 8'ha0);
		f = {LINK_CFG.no_tx_parity, LINK_CFG.raw_rx,
			LINK_CFG.transport_frame_header, LINK_CFG.anticoll_frame};
		chk(f, 4'ha);
		for (c = 0; c < 64; c++)
		begin
			r = c[5:4];
			if (c[3:0] == 4'h0)
				wr(RBFC_IDX_SPEED, {2'h0, r, 2'h0, r});
			s = {c[3], c[3:0]};
			v = (s >= pw_lo[r]) && (s <= pw_hi[r]);
			wr(RBFC_IDX_AFRAME, {3'h0, c[3:0], 1'h0});
			chk(LINK_CFG.pause_valid, v);
			chk(LINK_CFG.pause_width, v ? pw_base[r] + s : 0);
		end
		$display("framing done");
	endtask

	task t_cmds;
		wr(RBFC_IDX_SPEED, 8'h55);
		wr(RBFC_IDX_AFRAME, 8'hff);
		wr(RBFC_IDX_CMD, 8'h01);
		rdchk(RBFC_IDX_SPEED, 8'h00);
		rdchk(RBFC_IDX_AFRAME, 8'h00);
		DETECTED_RATE <= 4'h2;
		wr(RBFC_IDX_CMD, 8'h02);
		rdchk(RBFC_IDX_SPEED, 8'h22);
		wr(RBFC_IDX_CMD, 8'h03);
		rdchk(RBFC_IDX_SPEED, 8'h00);
		rdchk(8'h0a, 8'h00);
		chk(er, 1'h1);
		$display("commands done");
	endtask

	task t_frame;
		wr(RBFC_IDX_SPEED, 8'h11);
		start_frame(1'h1);
		chk(LINK_BUSY, 1'h1);
		wr(RBFC_IDX_SPEED, 8'h22);
		chk(LINK_CFG.send_rate, 4'h1);
		rdchk(RBFC_IDX_STATUS, 8'hff);
		end_frame;
		chk(LINK_BUSY, 1'h0);
		chk(LINK_CFG.send_rate, 4'h2);
		start_frame(1'h0);
		chk(LINK_BUSY, 1'h1);
		end_frame;
		chk(LINK_BUSY, 1'h0);
		md(1'h0, 4'h5);
		start_frame(1'h1);
		chk(LINK_BUSY, 1'h0);
		$display("frame done");
	endtask

	initial
	begin
		CLK = 1'h0;
		SRST = 1'h1;
		PSEL = 1'h0;
		PENABLE = 1'h0;
		PWRITE = 1'h0;
		PADDR = 32'h0;
		PWDATA = 32'h0;
		TARGET_MODE = 1'h0;
		OP_MODE = 4'h0;
		DETECTED_RATE = 4'h0;
		TX_FRAME_START = 1'h0;
		RX_FRAME_START = 1'h0;
		FRAME_DONE = 1'h0;
		repeat (16) @(posedge CLK);
		SRST <= 1'h0;
		t_reset;
		t_rates;
		t_mode;
		t_framing;
		t_cmds;
		t_frame;
		tally_and_finish;
	end
endmodule
